//--- rtl/ucrl_pkg.sv
package ucrl_pkg;

  localparam logic [2:0] ADDR_DATA      = 3'h0;
  localparam logic [2:0] ADDR_IER       = 3'h1;
  localparam logic [2:0] ADDR_ISR       = 3'h2;
  localparam logic [2:0] ADDR_LINE_CTL  = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STS = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH   = 3'h7;

  localparam logic [7:0] LCR_SPECIAL    = 8'hBF;
  localparam int         LCR_DLAB_BIT   = 7;
  localparam int         LCR_BREAK_BIT  = 6;
  localparam int         MCR_DTR_BIT    = 0;
  localparam int         MCR_RTS_BIT    = 1;
  localparam int         MCR_OUT1_BIT   = 2;
  localparam int         MCR_OUT2_BIT   = 3;
  localparam int         MCR_LOOP_BIT   = 4;
  localparam int         FCR_EN_BIT     = 0;
  localparam int         FCR_RXRST_BIT  = 1;
  localparam int         FCR_TXRST_BIT  = 2;
  localparam int         FCR_DMA_BIT    = 3;

  localparam logic [7:0] DLL_RESET      = 8'h01;
  localparam logic [7:0] DLM_RESET      = 8'h00;
  localparam logic [7:0] LCR_RESET      = 8'h00;
  localparam logic [3:0] IER_MASK       = 4'hF;
  localparam logic [4:0] MCR_MASK       = 5'h1F;
  localparam logic [3:0] ISR_NONE       = 4'h1;
  localparam logic [3:0] ISR_LINE       = 4'h6;
  localparam logic [3:0] ISR_RXDATA     = 4'h4;
  localparam logic [3:0] ISR_TXRDY      = 4'h2;
  localparam logic [3:0] ISR_MODEM      = 4'h0;

  localparam int         FIFO_WIDTH     = 8;
  localparam int         FIFO_DEPTH     = 8;

  typedef struct packed {
    logic [2:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } ucrl_bus_t;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic carrier_detect_n;
  } ucrl_modem_in_t;

endpackage : ucrl_pkg

//--- rtl/ucrl_fifo.sv
module ucrl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } ucrl_fifo_st_t;

  ucrl_fifo_st_t          st_q;
  ucrl_fifo_st_t          st_d;
  logic [WIDTH-1:0]       mem_q [DEPTH];
  logic                   push;
  logic                   pop;

  assign full      = st_q.cnt == (AW+1)'(DEPTH);
  assign empty     = st_q.cnt == '0;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[st_q.rp];
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  always_comb begin
    st_d = st_q;
    if (flush) begin
      st_d = '0;
    end else begin
      if (push) st_d.wp = st_q.wp + 1'b1;
      if (pop) st_d.rp = st_q.rp + 1'b1;
      if (push && !pop) st_d.cnt = st_q.cnt + 1'b1;
      if (pop && !push) st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_q[st_q.wp] <= in_data;
  end
endmodule : ucrl_fifo

//--- rtl/ucrl_channel.sv
module ucrl_channel (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire ucrl_pkg::ucrl_bus_t     bus,
  output logic                  [7:0]  rdata,
  input  wire logic                    tx_shift_out,
  output logic                         rx_shift_in,
  input  wire logic                    tx_shift_idle,
  input  wire logic                    rx_char_valid,
  input  wire logic             [7:0]  rx_char,
  input  wire logic             [2:0]  rx_char_err,
  input  wire logic                    tx_take,
  output logic                         tx_char_valid,
  output logic                  [7:0]  tx_char,
  output logic                  [15:0] divisor,
  output logic                  [7:0]  line_ctl,
  input  wire logic                    serial_in,
  output logic                         serial_out,
  output logic                         request_to_send_n,
  output logic                         terminal_ready_n,
  output logic                         reserved_output_one_n,
  output logic                         interrupt_output_enable_n,
  input  wire ucrl_pkg::ucrl_modem_in_t modem_in,
  output logic                         irq
);
  typedef struct packed {
    logic [7:0] dll;
    logic [7:0] divisor_high_byte;
    logic [3:0] interrupt_enable;
    logic [7:0] line_control;
    logic [4:0] modem_control;
    logic [7:0] scratch_pad;
    logic       fifo_en;
    logic       dma_mode;
    logic [1:0] trigger;
    logic       overrun;
    logic [2:0] err;
    logic       tx_ack;
    logic [3:0] delta;
    logic [3:0] msr_prev;
    logic [7:0] rdata;
  } ucrl_state_t;

  ucrl_state_t       st_q;
  ucrl_state_t       st_d;
  logic              loop_on;
  logic              dl_access;
  logic [3:0]        msr_now;
  logic              rx_push_ready;
  logic              rx_valid;
  logic [7:0]        rx_head;
  logic              rx_empty;
  logic              tx_in_ready;
  logic              tx_empty;
  logic              rx_pop;
  logic              tx_push;
  logic              rx_flush;
  logic              tx_flush;
  logic [3:0]        isr_code;
  logic              fcr_write;

  function automatic logic hit(input ucrl_pkg::ucrl_bus_t b, input logic [2:0] a);
    return b.addr == a;
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // loopback steering
  // loopback select
  assign loop_on = st_q.modem_control[ucrl_pkg::MCR_LOOP_BIT];
  assign rx_shift_in = loop_on ? tx_shift_out : serial_in;
  assign serial_out = loop_on ? 1'b1 : tx_shift_out;
  assign request_to_send_n = loop_on ? 1'b1 : !st_q.modem_control[ucrl_pkg::MCR_RTS_BIT];
  assign terminal_ready_n  = loop_on ? 1'b1 : !st_q.modem_control[ucrl_pkg::MCR_DTR_BIT];
  assign reserved_output_one_n     = loop_on ? 1'b1 : !st_q.modem_control[ucrl_pkg::MCR_OUT1_BIT];
  assign interrupt_output_enable_n = loop_on ? 1'b1 : !st_q.modem_control[ucrl_pkg::MCR_OUT2_BIT];

  // inputs ignored, internal modem outputs looped
  always_comb begin
    if (loop_on) begin
      msr_now = {st_q.modem_control[ucrl_pkg::MCR_OUT2_BIT], st_q.modem_control[ucrl_pkg::MCR_OUT1_BIT],
                 st_q.modem_control[ucrl_pkg::MCR_DTR_BIT], st_q.modem_control[ucrl_pkg::MCR_RTS_BIT]};
    end else begin
      msr_now = {!modem_in.carrier_detect_n, !modem_in.ri_n, !modem_in.dsr_n, !modem_in.cts_n};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  // divisor window
  assign dl_access = st_q.line_control[ucrl_pkg::LCR_DLAB_BIT] && (st_q.line_control != ucrl_pkg::LCR_SPECIAL);
  assign rx_pop    = bus.rd && hit(bus, ucrl_pkg::ADDR_DATA) && !dl_access;
  assign tx_push   = bus.wr && hit(bus, ucrl_pkg::ADDR_DATA) && !dl_access && tx_in_ready;
  assign fcr_write = bus.wr && hit(bus, ucrl_pkg::ADDR_ISR);
  assign rx_flush  = fcr_write && (!bus.wdata[ucrl_pkg::FCR_EN_BIT] || bus.wdata[ucrl_pkg::FCR_RXRST_BIT]);
  assign tx_flush  = fcr_write && (!bus.wdata[ucrl_pkg::FCR_EN_BIT] || bus.wdata[ucrl_pkg::FCR_TXRST_BIT]);

  ucrl_fifo #(.WIDTH(ucrl_pkg::FIFO_WIDTH), .DEPTH(ucrl_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (rx_flush),
    .in_valid  (rx_char_valid),
    .in_ready  (rx_push_ready),
    .in_data   (rx_char),
    .out_valid (rx_valid),
    .out_ready (rx_pop),
    .out_data  (rx_head),
    .empty     (rx_empty),
    .full      ()
  );

  ucrl_fifo #(.WIDTH(ucrl_pkg::FIFO_WIDTH), .DEPTH(ucrl_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (tx_flush),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (bus.wdata),
    .out_valid (tx_char_valid),
    .out_ready (tx_take),
    .out_data  (tx_char),
    .empty     (tx_empty),
    .full      ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // interrupt source
  always_comb begin
    if (st_q.interrupt_enable[2] && (st_q.overrun || (st_q.err != 3'h0))) begin
      isr_code = ucrl_pkg::ISR_LINE;
    end else if (st_q.interrupt_enable[0] && rx_valid) begin
      isr_code = ucrl_pkg::ISR_RXDATA;
    end else if (st_q.interrupt_enable[1] && tx_empty && !st_q.tx_ack) begin
      isr_code = ucrl_pkg::ISR_TXRDY;
    end else if (st_q.interrupt_enable[3] && (st_q.delta != 4'h0)) begin
      isr_code = ucrl_pkg::ISR_MODEM;
    end else begin
      isr_code = ucrl_pkg::ISR_NONE;
    end
  end
  assign irq = (isr_code != ucrl_pkg::ISR_NONE) && st_q.modem_control[ucrl_pkg::MCR_OUT2_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    st_d = st_q;
    st_d.msr_prev = msr_now;
    st_d.delta = st_q.delta | (msr_now ^ st_q.msr_prev);
    if (rx_char_valid && !rx_push_ready) st_d.overrun = 1'b1;
    if (rx_char_valid) st_d.err = st_q.err | rx_char_err;
    if (tx_push) st_d.tx_ack = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        ucrl_pkg::ADDR_DATA: begin
          if (dl_access) st_d.dll = bus.wdata;
        end
        ucrl_pkg::ADDR_IER: begin
          if (dl_access) st_d.divisor_high_byte = bus.wdata;
          else st_d.interrupt_enable = bus.wdata[3:0] & ucrl_pkg::IER_MASK;
        end
        ucrl_pkg::ADDR_ISR: begin
          st_d.fifo_en = bus.wdata[ucrl_pkg::FCR_EN_BIT];
          if (bus.wdata[ucrl_pkg::FCR_EN_BIT]) begin
            st_d.dma_mode = bus.wdata[ucrl_pkg::FCR_DMA_BIT];
            st_d.trigger  = bus.wdata[7:6];
          end
        end
        ucrl_pkg::ADDR_LINE_CTL:  st_d.line_control = bus.wdata;
        ucrl_pkg::ADDR_MODEM_CTL: st_d.modem_control = bus.wdata[4:0] & ucrl_pkg::MCR_MASK;
        ucrl_pkg::ADDR_LINE_STAT: ;
        ucrl_pkg::ADDR_MODEM_STS: ;
        ucrl_pkg::ADDR_SCRATCH:   st_d.scratch_pad = bus.wdata;
      endcase
    end
    st_d.rdata = st_q.rdata;
    if (bus.rd) begin
      unique case (bus.addr)
        ucrl_pkg::ADDR_DATA: begin
          st_d.rdata = dl_access ? st_q.dll : rx_head;
        end
        ucrl_pkg::ADDR_IER: begin
          st_d.rdata = dl_access ? st_q.divisor_high_byte : {4'h0, st_q.interrupt_enable};
        end
        ucrl_pkg::ADDR_ISR: begin
          st_d.rdata = {{2{st_q.fifo_en}}, 2'h0, isr_code};
          if (isr_code == ucrl_pkg::ISR_TXRDY) st_d.tx_ack = 1'b1;
        end
        ucrl_pkg::ADDR_LINE_CTL:  st_d.rdata = st_q.line_control;
        ucrl_pkg::ADDR_MODEM_CTL: st_d.rdata = {3'h0, st_q.modem_control};
        ucrl_pkg::ADDR_LINE_STAT: begin
          st_d.rdata = {(st_q.err != 3'h0), tx_empty && tx_shift_idle, tx_empty,
                        st_q.err[2], st_q.err[1], st_q.err[0], st_q.overrun, !rx_empty};
          st_d.overrun = rx_char_valid && !rx_push_ready;
          st_d.err = rx_char_valid ? rx_char_err : 3'h0;
        end
        ucrl_pkg::ADDR_MODEM_STS: begin
          st_d.rdata = {msr_now, st_q.delta};
          st_d.delta = msr_now ^ st_q.msr_prev;
        end
        ucrl_pkg::ADDR_SCRATCH:   st_d.rdata = st_q.scratch_pad;
      endcase
    end
  end

  assign rdata    = st_q.rdata;
  assign divisor  = {st_q.divisor_high_byte, st_q.dll};
  assign line_ctl = st_q.line_control;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q     <= '0;
      st_q.dll <= ucrl_pkg::DLL_RESET;
      st_q.divisor_high_byte <= ucrl_pkg::DLM_RESET;
      st_q.line_control <= ucrl_pkg::LCR_RESET;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : ucrl_channel

//--- verification/ucrl_channel_properties.sv
module ucrl_channel_chk (
  input wire logic                clk,
  input wire logic                resetn,
  input wire ucrl_pkg::ucrl_bus_t bus,
  input wire logic [7:0]          rdata,
  input wire logic                tx_shift_out,
  input wire logic                rx_shift_in,
  input wire logic [15:0]         divisor,
  input wire logic [7:0]          line_ctl,
  input wire logic                serial_out,
  input wire logic                request_to_send_n,
  input wire logic                terminal_ready_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       loop_q;
  logic [7:0] spr_q;
  // shadow of loopback bit and scratch byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop_q <= 1'b0;
      spr_q  <= 8'h00;
    end else if (bus.wr) begin
      if (bus.addr == 3'h4) loop_q <= bus.wdata[4];
      if (bus.addr == 3'h7) spr_q <= bus.wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  AST_LOOP_TX_MARK: assert property (loop_q |-> serial_out)
    else $error("tx pin not high in loopback");
  AST_LOOP_MODEM_OFF: assert property (loop_q |-> request_to_send_n && terminal_ready_n)
    else $error("modem outputs asserted in loopback");
  AST_LOOP_ROUTE: assert property (loop_q |-> rx_shift_in == tx_shift_out)
    else $error("receive input not fed from transmit output");
  AST_NORMAL_TX: assert property (!loop_q && !line_ctl[6] |-> serial_out == tx_shift_out)
    else $error("tx pin not following shifter");
  AST_RDATA_HOLD: assert property (!bus.rd |=> $stable(rdata))
    else $error("read data moved without a read");
  AST_SCRATCH_READ: assert property (bus.rd && !bus.wr && bus.addr == 3'h7 |=> rdata == spr_q)
    else $error("scratch read wrong");
  AST_IER_UPPER: assert property (bus.rd && bus.addr == 3'h1 && !line_ctl[7] |=> rdata[7:4] == 4'h0)
    else $error("interrupt enable upper bits not zero");
  AST_MCR_UPPER: assert property (bus.rd && bus.addr == 3'h4 |=> rdata[7:5] == 3'h0)
    else $error("modem control upper bits not zero");
  AST_DIV_LOW: assert property (bus.wr && bus.addr == 3'h0 && line_ctl[7] && line_ctl != ucrl_pkg::LCR_SPECIAL
    |=> divisor[7:0] == $past(bus.wdata))
    else $error("divisor low byte not written");
  cover property (bus.wr && bus.addr == 3'h4 && bus.wdata[4]);
  cover property (bus.rd && bus.addr == 3'h7);
  cover property (bus.wr && bus.addr == 3'h0 && line_ctl[7]);
endmodule : ucrl_channel_chk

bind ucrl_channel ucrl_channel_chk chk_u (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata),
  .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in), .divisor(divisor), .line_ctl(line_ctl),
  .serial_out(serial_out), .request_to_send_n(request_to_send_n), .terminal_ready_n(terminal_ready_n));

//--- verification/ucrl_line_model.sv
module ucrl_line_model (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        tx_char_valid,
  input wire logic [7:0]  tx_char,
  input wire logic        rx_shift_in,
  output logic            tx_take,
  output logic            tx_shift_out,
  output logic            tx_shift_idle,
  output logic            rx_char_valid,
  output logic     [7:0]  rx_char,
  output logic     [2:0]  rx_char_err,
  output logic            serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] tsh;
  logic [3:0] tcnt;
  logic [3:0] rcnt;
  logic [7:0] rsh;
  assign serial_in     = 1'b1;
  assign rx_char_err   = 3'h0;
  assign tx_shift_idle = (tcnt == 4'h0);
  assign tx_take       = tx_shift_idle & tx_char_valid;
  assign tx_shift_out  = tx_shift_idle | tsh[0];
  // frame: start, 8 data lsb first, stop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tcnt <= 4'h0;
      rcnt <= 4'h0;
      tsh <= 10'h3FF;
      rsh <= 8'h00;
      rx_char <= 8'h00;
      rx_char_valid <= 1'b0;
    end else begin
      rx_char_valid <= 1'b0;
      if (tx_take) begin
        tsh <= {1'b1, tx_char, 1'b0};
        tcnt <= 4'hA;
      end else if (tcnt != 4'h0) begin
        tsh <= tsh >> 1;
        tcnt <= tcnt - 4'h1;
      end
      if (rcnt == 4'h0 && !rx_shift_in) rcnt <= 4'h9;
      else if (rcnt > 4'h1) begin
        rsh <= {rx_shift_in, rsh[7:1]};
        rcnt <= rcnt - 4'h1;
      end else if (rcnt == 4'h1) begin
        rx_char_valid <= 1'b1;
        rx_char <= rsh;
        rcnt <= 4'h0;
      end
    end
  end
endmodule : ucrl_line_model

//--- verification/uart_channel_regmap_loopback_test.sv
module uart_channel_regmap_loopback_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk = 1'b0;
  logic                     resetn = 1'b0;
  logic                     pend = 1'b0;
  ucrl_pkg::ucrl_bus_t      bus = '0;
  ucrl_pkg::ucrl_modem_in_t modem_in = '1;
  logic                     tx_shift_out, rx_shift_in, tx_shift_idle, rx_char_valid, tx_take, tx_char_valid;
  logic                     serial_in, serial_out, request_to_send_n, terminal_ready_n;
  logic [7:0]               rx_char, tx_char, rdata, line_ctl;
  logic [2:0]               rx_char_err;
  logic [15:0]              divisor;
  logic [15:0]              exp_q[$];
  logic [31:0]              r;
  int                       failures = 0;
  int                       compares = 0;

  initial forever #25 clk = ~clk;

  ucrl_channel dut_u (.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .tx_shift_out(tx_shift_out),
    .rx_shift_in(rx_shift_in), .tx_shift_idle(tx_shift_idle), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_char_err(rx_char_err), .tx_take(tx_take), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .divisor(divisor), .line_ctl(line_ctl), .serial_in(serial_in),
    .serial_out(serial_out), .request_to_send_n(request_to_send_n), .terminal_ready_n(terminal_ready_n),
    .reserved_output_one_n(), .interrupt_output_enable_n(), .modem_in(modem_in), .irq());
  ucrl_line_model line_u (.clk(clk), .resetn(resetn), .tx_char_valid(tx_char_valid), .tx_char(tx_char),
    .rx_shift_in(rx_shift_in), .tx_take(tx_take), .tx_shift_out(tx_shift_out),
    .tx_shift_idle(tx_shift_idle), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_char_err(rx_char_err), .serial_in(serial_in));
  ////////////////////////////////////////
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic chk_read(input logic [7:0] got, input logic [15:0] me);
    chk_pin(16'(got & me[15:8]), 16'(me[7:0] & me[15:8]));
  endtask : chk_read
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 1'b0, 1'b1, d};
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    bus <= '{a, 1'b1, 1'b0, 8'h00};
    exp_q.push_back({m, e});
  endtask : rd
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      bus <= '0;
    end
    @(negedge clk);
  endtask : idle
  task automatic tally_and_finish;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // read data arrives one cycle after the strobe
  always @(posedge clk) begin
    if (pend) chk_read(rdata, exp_q.pop_front());
    pend = bus.rd;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(97));
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    wr(3'h3, 8'h80);
    rd(3'h0, 8'h01);
    rd(3'h1, 8'h00);
    r = $urandom;
    wr(3'h0, r[7:0]);
    wr(3'h1, r[15:8]);
    rd(3'h0, r[7:0]);
    rd(3'h1, r[15:8]);
    idle(2);
    chk_pin(divisor, r[15:0]);
    wr(3'h3, r[23:16] & 8'h3F);
    rd(3'h3, r[23:16] & 8'h3F);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'h0F);
    wr(3'h1, 8'h02);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h01);
    rd(3'h2, 8'hC1);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      wr(3'h7, r[7:0]);
      rd(3'h7, r[7:0]);
    end
    rd(3'h5, 8'h60);
    wr(3'h5, 8'hFF);
    wr(3'h6, 8'hFF);
    rd(3'h5, 8'h60);
    wr(3'h4, 8'hFF);
    rd(3'h4, 8'h1F);
    wr(3'h4, 8'h13);
    r = $urandom;
    modem_in <= r[3:0];
    idle(2);
    chk_pin(16'({serial_out, request_to_send_n, terminal_ready_n}), 16'h0007);
    rd(3'h6, 8'h30, 8'hF0);
    rd(3'h6, 8'h30);
    r = $urandom;
    wr(3'h0, r[7:0]);
    idle(30);
    rd(3'h5, 8'h61);
    wr(3'h1, 8'h01);
    rd(3'h2, 8'hC4);
    wr(3'h1, 8'h00);
    rd(3'h0, r[7:0]);
    rd(3'h5, 8'h60);
    wr(3'h4, 8'h03);
    wr(3'h0, r[15:8]);
    idle(30);
    chk_pin(16'({request_to_send_n, terminal_ready_n}), 16'h0000);
    rd(3'h5, 8'h60);
    idle(3);
    tally_and_finish();
  end
endmodule : uart_channel_regmap_loopback_test
